// File: hdl/sru_errq.sv
`timescale 1ns/1ns
`default_nettype none
module sru_errq
    import sru_pkg::*;
#(
    parameter int DEPTH = EQ_DEPTH,
    parameter int W     = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // control
    input  wire logic         clr,
    input  wire logic         push,
    input  wire logic [W-1:0] din,
    input  wire logic         pop,
    // state
    output logic      [W-1:0] dout,
    output logic              empty,
    output logic              full
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam bit [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];  // entry storage
    logic [AW-1:0] rd_reg;       // oldest entry
    logic [AW-1:0] wr_reg;       // next free slot
    logic [CW-1:0] cnt_reg;      // entries held

    // ------------------------------------------------
    // decode
    // ------------------------------------------------
    assign empty = (cnt_reg == '0);
    assign full  = (cnt_reg == CW'(DEPTH));
    assign dout  = mem[rd_reg];
    // newest error dropped when full
    // (RULE23) keep oldest
    wire do_push = push && (!full || clr);
    // a push that meets a clear lands in the emptied queue
    wire [AW-1:0] wr_slot = clr ? '0 : wr_reg;
    wire do_pop  = pop && !empty && !clr;

    // ------------------------------------------------
    // pointers and count
    // ------------------------------------------------
    // (RULE4) fifo order
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_reg  <= '0;
            wr_reg  <= '0;
            cnt_reg <= '0;
        end else if (clr) begin
            rd_reg  <= '0;
            wr_reg  <= AW'(do_push);
            cnt_reg <= CW'(do_push);
        end else begin
            if (do_push) begin
                wr_reg <= (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_reg <= (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
        end
    end

    // entry write, one slot per index
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_slot] <= din;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_drop_full;
        full && push && !pop && !clr |=> full && $stable(wr_reg);
    endproperty
    a_drop_full: assert property (p_drop_full) // RULE23
        else $error("push into full queue changed it");

    property p_cnt_max;
        cnt_reg <= CW'(DEPTH);
    endproperty
    a_cnt_max: assert property (p_cnt_max) // RULE4
        else $error("error queue count above depth");
endmodule // sru_errq
`default_nettype wire

// File: hdl/sru_pkg.sv
package sru_pkg;
    // ------------------------------------------------
    // widths, depths and bit positions
    // ------------------------------------------------
    localparam int       REG_W    = 8;
    localparam int       EQ_DEPTH = 10;
    localparam int       STB_MAV  = 4;
    localparam int       STB_ESB  = 5;
    localparam int       STB_RQS  = 6;
    localparam int       ESR_OPC  = 0;
    localparam int       ESR_DEV  = 3;
    // reset values
    localparam bit [7:0] ESE_RST  = 8'h00;
    localparam bit [7:0] PPE_RST  = 8'h00;
    localparam bit [7:0] ESR_RST  = 8'h00;
    // fixed answers
    localparam bit [7:0] IDN_SER  = 8'h30;
    localparam bit [7:0] NOERR    = 8'h00;
    localparam bit [7:0] OPC_ONE  = 8'h01;

    // ------------------------------------------------
    // commands, answers, carriers
    // ------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NONE, CMD_CLS, CMD_ESE_WR, CMD_ESE_RD,
        CMD_ESR_RD, CMD_ERR_RD, CMD_IDN_RD,
        CMD_IST_RD, CMD_OPC, CMD_OPC_RD,
        CMD_PRE_WR, CMD_PRE_RD, CMD_RST, CMD_DCL
    } sru_cmd_t;

    typedef enum logic [1:0] {
        RK_VALUE, RK_ERROR, RK_NOERR, RK_IDN
    } sru_rkind_t;

    typedef enum logic {
        W_IDLE, W_ARMED
    } sru_wait_t;

    typedef struct packed {
        sru_cmd_t   code;  // decoded command
        logic [7:0] arg;   // mask argument
    } sru_req_t;

    typedef struct packed {
        sru_rkind_t  kind; // answer type
        logic [7:0]  num;  // value or error code
        logic [31:0] aux;  // idn revision fields
    } sru_resp_t;
endpackage

// File: hdl/sru_ppoll.sv
`timescale 1ns/1ns
`default_nettype none
module sru_ppoll
    import sru_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // status inputs
    input  wire logic [7:0] stb,
    input  wire logic [7:0] ppe,
    // configuration from controller
    input  wire logic       ppc_valid,
    input  wire logic       ppc_clear,
    input  wire logic       ppc_sense,
    input  wire logic [2:0] ppc_line,
    // poll pin and data lines
    input  wire logic       pp_poll,
    output logic            ist,
    output logic      [7:0] dio_o,
    output logic      [7:0] dio_oe
);
    logic       en_reg;    // configured to respond
    logic       sense_reg; // sense bit
    logic [2:0] line_reg;  // data line chosen
    logic       s1_reg;    // poll sync stage 1
    logic       s2_reg;    // poll sync stage 2
    logic [7:0] oe_reg;    // line drive

    // ------------------------------------------------
    // individual status
    // ------------------------------------------------
    // (RULE14) status and enable
    assign ist    = |(stb & ppe);
    wire   match  = en_reg && (ist == sense_reg) && s2_reg;
    assign dio_o  = 8'h00;  // lines are low-true
    assign dio_oe = oe_reg;

    // ------------------------------------------------
    // configuration held from controller
    // ------------------------------------------------
    // (RULE16) controller picks line
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            en_reg    <= 1'b0;
            sense_reg <= 1'b0;
            line_reg  <= 3'h0;
        end else if (ppc_clear) begin
            en_reg    <= 1'b0;
        end else if (ppc_valid) begin
            en_reg    <= 1'b1;
            sense_reg <= ppc_sense;
            line_reg  <= ppc_line;
        end
    end

    // pin sync then line drive
    // (RULE15) drive on match
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            oe_reg <= 8'h00;
        end else begin
            s1_reg <= pp_poll;
            s2_reg <= s1_reg;
            oe_reg <= match ? (8'h01 << line_reg) : 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_pp_drive;
        en_reg && $stable(en_reg) && (ist == sense_reg)
            && pp_poll [*3] ##1 (ist == sense_reg) |-> dio_oe[line_reg];
    endproperty
    a_pp_drive: assert property (p_pp_drive) // RULE15
        else $error("poll match did not drive line");

    property p_pp_quiet;
        !en_reg ##1 !en_reg |-> dio_oe == 8'h00;
    endproperty
    a_pp_quiet: assert property (p_pp_quiet) // RULE15
        else $error("unconfigured device drove poll");
endmodule // sru_ppoll
`default_nettype wire

// File: hdl/sru_top.sv
// Behaviour
// (RULE1) clear status zeroes events, queue, byte
// (RULE2) clear status keeps message available
// (RULE3) clear status cancels operation complete waits
// (RULE4) ten entry error fifo, read pops
// (RULE5) empty queue answers no error
// (RULE6) serial errors echoed, not queued
// (RULE7) error answer: negative code, text
// (RULE8) summary bit five from masked events
// (RULE9) event mask zero at power up
// (RULE10) host mask values 0 to 255
// (RULE11) mask query returns mask, no effect
// (RULE12) event read clears all but bit three
// (RULE13) identity: maker, model, 0, revision
// (RULE14) individual status from byte and enable
// (RULE15) poll match drives configured line
// (RULE16) controller configures sense and line
// (RULE17) complete sets bit zero, sticky
// (RULE18) pending: acquire, fixed store, ranging
// (RULE19) complete query answers 1 when idle
// (RULE20) clear, reset, device clear drop query
// (RULE21) poll enable eight bits, zero reset
// (RULE22) service request once, bit six
// (RULE23) full queue drops new errors
`timescale 1ns/1ns
`default_nettype none
module sru_top
    import sru_pkg::*;
#(
    parameter bit [15:0] REV_LEVEL = 16'h0001, // arbitrary
    parameter bit [15:0] REV_DATE  = 16'h0000  // arbitrary
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // decoded command port
    input  wire logic       req_valid,
    input  wire sru_req_t   req,
    output logic            req_ready,
    // answer port
    output logic            resp_valid,
    output sru_resp_t       resp,
    // error source
    input  wire logic       err_valid,
    input  wire logic [7:0] err_code,
    input  wire logic       err_serial,
    input  wire logic       echo_mode,
    // pending operations
    input  wire logic       acq_single,
    input  wire logic       store_fixed,
    input  wire logic       ranging,
    // event sources
    input  wire logic [7:0] esr_events,
    input  wire logic [7:0] dev_event,
    input  wire logic [7:0] device_event_mask,
    output logic            dev_event_clr,
    // output buffer and service request
    input  wire logic       out_pending,
    input  wire logic [7:0] sre_mask,
    input  wire logic       spoll_ack,
    output logic      [7:0] stb,
    output logic            srq,
    // parallel poll
    input  wire logic       ppc_valid,
    input  wire logic       ppc_clear,
    input  wire logic       ppc_sense,
    input  wire logic [2:0] ppc_line,
    input  wire logic       pp_poll,
    output logic      [7:0] dio_o,
    output logic      [7:0] dio_oe
);
    // ------------------------------------------------
    // state
    // ------------------------------------------------
    logic [7:0] ese_reg;      // event enable mask
    logic [7:0] esr_reg;      // event status, bit 3 unused
    logic [7:0] ppe_reg;      // poll enable mask
    logic       rqs_reg;      // service requested
    logic       sum_reg;      // last request summary
    sru_wait_t  opc_reg;      // complete command wait
    sru_wait_t  opq_reg;      // complete query wait
    logic       rv_reg;       // answer valid
    sru_resp_t  resp_reg;     // answer held
    sru_resp_t  resp_next;    // answer chosen
    logic       ist;          // individual status
    logic [7:0] q_dout;       // oldest error
    logic       q_empty;      // queue empty
    logic       q_full;       // queue full

    // ------------------------------------------------
    // command decode
    // ------------------------------------------------
    wire take    = req_valid && req_ready;
    wire is_cls  = take && req.code == CMD_CLS;
    wire is_rst  = take && req.code == CMD_RST;
    wire is_dcl  = take && req.code == CMD_DCL;
    wire ese_wr  = take && req.code == CMD_ESE_WR;
    wire pre_wr  = take && req.code == CMD_PRE_WR;
    wire esr_rd  = take && req.code == CMD_ESR_RD;
    wire err_rd  = take && req.code == CMD_ERR_RD;
    wire opc_cmd = take && req.code == CMD_OPC;
    wire opq_cmd = take && req.code == CMD_OPC_RD;
    wire query   = take && (req.code == CMD_ESE_RD
                 || req.code == CMD_ESR_RD
                 || req.code == CMD_ERR_RD
                 || req.code == CMD_IDN_RD
                 || req.code == CMD_IST_RD
                 || req.code == CMD_PRE_RD);

    // ------------------------------------------------
    // errors: echo or queue
    // ------------------------------------------------
    // (RULE6) serial errors echoed
    wire echo_err = err_valid && err_serial && echo_mode;
    wire q_push   = err_valid && !(err_serial && echo_mode);
    // echo holds the answer port, so stall commands
    assign req_ready = !echo_err;
    wire q_pop    = err_rd && !q_empty;

    // ------------------------------------------------
    // pending and summaries
    // ------------------------------------------------
    // (RULE18) pending operations
    wire pending  = acq_single || store_fixed || ranging;
    // (RULE12) bit three follows device events
    wire dev_sum  = |(dev_event & device_event_mask);
    wire [7:0] esr_view = {esr_reg[7:4], dev_sum, esr_reg[2:0]};
    // (RULE8) masked summary bit
    wire esb      = |(esr_view & ese_reg);
    // (RULE2) message available from buffers only
    wire mav      = out_pending;
    wire [7:0] stb_base = {1'b0, 1'b0, esb, mav, 4'h0};
    // (RULE22) bit six while requesting
    assign stb    = stb_base | (8'(rqs_reg) << STB_RQS);
    wire req_sum  = |(stb_base & sre_mask);
    assign srq    = rqs_reg;
    // (RULE1) clear device events too
    assign dev_event_clr = is_cls;

    // ------------------------------------------------
    // operation complete handling
    // ------------------------------------------------
    // (RULE3) clear status cancels
    wire opc_cancel = is_cls || is_rst;
    // (RULE20) query dropped on clears
    wire opq_cancel = is_cls || is_rst || is_dcl;
    wire opc_hit  = opc_reg == W_ARMED && !pending && !opc_cancel;
    // answer port busy this cycle, query waits
    wire opq_fire = opq_reg == W_ARMED && !pending && !opq_cancel
                 && !echo_err && !query;

    // ------------------------------------------------
    // masks and service request
    // ------------------------------------------------
    // (RULE9) masks zero at reset
    // (RULE21) poll enable written whole
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ese_reg <= ESE_RST;
            ppe_reg <= PPE_RST;
        end else begin
            if (ese_wr) begin
                ese_reg <= req.arg;
            end
            if (pre_wr) begin
                ppe_reg <= req.arg;
            end
        end
    end

    // one request per rising summary, set beats clear
    // (RULE22) request once per event
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sum_reg <= 1'b0;
            rqs_reg <= 1'b0;
        end else begin
            sum_reg <= req_sum;
            if (req_sum && !sum_reg) begin
                rqs_reg <= 1'b1;
            end else if (spoll_ack || is_cls) begin
                rqs_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // event status register
    // ------------------------------------------------
    // clear first, then new events win
    // (RULE12) read clears
    // (RULE17) complete bit sticky
    wire [7:0] esr_keep = (is_cls || esr_rd) ? 8'h00 : esr_reg;
    wire [7:0] esr_set  = esr_events | (8'(opc_hit) << ESR_OPC);
    wire [7:0] esr_next = (esr_keep | esr_set) & ~(8'h01 << ESR_DEV);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            esr_reg <= ESR_RST;
        end else begin
            esr_reg <= esr_next;
        end
    end

    // ------------------------------------------------
    // complete waits
    // ------------------------------------------------
    // (RULE17) arm, fire when idle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opc_reg <= W_IDLE;
        end else begin
            case (opc_reg)
                W_IDLE: begin
                    if (opc_cmd) begin
                        opc_reg <= W_ARMED;
                    end
                end
                W_ARMED: begin
                    if (opc_cancel || !pending) begin
                        opc_reg <= W_IDLE;
                    end
                end
                default: opc_reg <= W_IDLE;
            endcase
        end
    end

    // (RULE19) query answers when idle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opq_reg <= W_IDLE;
        end else begin
            case (opq_reg)
                W_IDLE: begin
                    if (opq_cmd) begin
                        opq_reg <= W_ARMED;
                    end
                end
                W_ARMED: begin
                    if (opq_cancel || opq_fire) begin
                        opq_reg <= W_IDLE;
                    end
                end
                default: opq_reg <= W_IDLE;
            endcase
        end
    end

    // ------------------------------------------------
    // answer selection: echo, query, complete
    // ------------------------------------------------
    always_comb begin
        resp_next = '{kind: RK_VALUE, num: 8'h00, aux: 32'h0};
        if (echo_err) begin
            // (RULE7) negative code, text by code
            resp_next.kind = RK_ERROR;
            resp_next.num  = err_code;
        end else if (query) begin
            case (req.code)
                // (RULE11) mask read, no effect
                CMD_ESE_RD: resp_next.num = ese_reg;
                CMD_ESR_RD: resp_next.num = esr_view;
                CMD_PRE_RD: resp_next.num = ppe_reg;
                // (RULE14) status on query
                CMD_IST_RD: resp_next.num = 8'(ist);
                CMD_IDN_RD: begin
                    // (RULE13) serial 0, revision pair
                    resp_next.kind = RK_IDN;
                    resp_next.num  = IDN_SER;
                    resp_next.aux  = {REV_LEVEL, REV_DATE};
                end
                CMD_ERR_RD: begin
                    // (RULE5) empty queue answer
                    resp_next.kind = q_empty ? RK_NOERR : RK_ERROR;
                    resp_next.num  = q_empty ? NOERR : q_dout;
                end
                default: resp_next.num = 8'h00;
            endcase
        end else if (opq_fire) begin
            resp_next.num = OPC_ONE;
        end
    end

    // answer register, one cycle pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rv_reg   <= 1'b0;
            resp_reg <= '{kind: RK_VALUE, num: 8'h00, aux: 32'h0};
        end else begin
            rv_reg   <= echo_err || query || opq_fire;
            resp_reg <= resp_next;
        end
    end
    assign resp_valid = rv_reg;
    assign resp       = resp_reg;

    // ------------------------------------------------
    // leaves
    // ------------------------------------------------
    sru_errq #(.DEPTH(EQ_DEPTH), .W(8)) u_errq (
        .clk    (clk),
        .arst_n (arst_n),
        .clr    (is_cls),
        .push   (q_push),
        .din    (err_code),
        .pop    (q_pop),
        .dout   (q_dout),
        .empty  (q_empty),
        .full   (q_full)
    );

    sru_ppoll u_ppoll (
        .clk       (clk),
        .arst_n    (arst_n),
        .stb       (stb),
        .ppe       (ppe_reg),
        .ppc_valid (ppc_valid),
        .ppc_clear (ppc_clear),
        .ppc_sense (ppc_sense),
        .ppc_line  (ppc_line),
        .pp_poll   (pp_poll),
        .ist       (ist),
        .dio_o     (dio_o),
        .dio_oe    (dio_oe)
    );

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_opc_armed;
        opc_cmd ##1 (opc_reg == W_ARMED);
    endsequence
    sequence s_opc_done;
        !pending && !opc_cancel;
    endsequence
    property p_opc_set;
        s_opc_armed ##0 s_opc_done |=> esr_reg[ESR_OPC];
    endproperty
    a_opc_set: assert property (p_opc_set) // RULE17
        else $error("complete bit not set after wait");

    property p_opc_hold;
        esr_reg[ESR_OPC] && !is_cls && !esr_rd |=> esr_reg[ESR_OPC];
    endproperty
    a_opc_hold: assert property (p_opc_hold) // RULE17
        else $error("complete bit dropped early");

    property p_cls;
        is_cls && esr_events == 8'h00 && !q_push && (sum_reg || !req_sum)
            |=> esr_reg == 8'h00 && q_empty && !stb[STB_RQS];
    endproperty
    a_cls: assert property (p_cls) // RULE1
        else $error("clear status left state behind");

    property p_esr_rd;
        esr_rd && esr_events == 8'h00 && !opc_hit |=> esr_reg == 8'h00;
    endproperty
    a_esr_rd: assert property (p_esr_rd) // RULE12
        else $error("event read did not clear");

    property p_ese_rd;
        take && req.code == CMD_ESE_RD |=> resp_valid
            && resp.num == $past(ese_reg) && $stable(ese_reg);
    endproperty
    a_ese_rd: assert property (p_ese_rd) // RULE11
        else $error("mask query wrong");

    property p_esb;
        ese_wr && req.arg == 8'h00 |=> !stb[STB_ESB];
    endproperty
    a_esb: assert property (p_esb) // RULE8
        else $error("summary set with zero mask");

    property p_opq;
        opq_cmd ##1 (!pending && !opq_cancel && !echo_err && !query)
            |=> resp_valid && resp.num == OPC_ONE;
    endproperty
    a_opq: assert property (p_opq) // RULE19
        else $error("complete query gave no answer");

    property p_opq_drop;
        opq_cancel |=> opq_reg == W_IDLE && !(resp_valid
            && !$past(query) && !$past(echo_err));
    endproperty
    a_opq_drop: assert property (p_opq_drop) // RULE20
        else $error("cancelled query still answered");

    property p_noerr;
        err_rd && q_empty |=> resp.kind == RK_NOERR;
    endproperty
    a_noerr: assert property (p_noerr) // RULE5
        else $error("empty queue gave entry");

    property p_echo;
        echo_err |=> resp_valid && resp.kind == RK_ERROR
            && resp.num == $past(err_code);
    endproperty
    a_echo: assert property (p_echo) // RULE6
        else $error("echoed error not sent");
endmodule // sru_top
`default_nettype wire

// File: tb/sru_host.sv
`timescale 1ns/1ns
`default_nettype none
module sru_host
    import sru_pkg::*;
(
    // command link
    input  wire logic      clk,
    input  wire logic      resp_valid,
    input  wire sru_resp_t resp,
    output var logic       req_valid,
    output var sru_req_t   req
);
    // idle link at time zero
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // one command: drive, hold one edge, sample the answer that the edge made, release
    // masks 0 to 255
    task automatic ask(input sru_cmd_t c, input logic [7:0] a,
                       output logic v, output sru_resp_t r);
        @(negedge clk);
        req_valid = 1'b1;
        req       = '{c, a};
        @(negedge clk);
        v = resp_valid;
        r = resp;
        req_valid = 1'b0;
        req       = '{CMD_NONE, ~a};
    endtask
endmodule // sru_host
`default_nettype wire

// File: tb/sru_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %0h exp %0h", $time, a, b); end end
module sru_top_tb;
    import sru_pkg::*;
    // design inputs and outputs
    logic       clk, arst_n, req_valid, resp_valid, req_ready;
    logic       err_valid, err_serial, echo_mode, acq_single, store_fixed;
    logic       ranging, out_pending, spoll_ack, ppc_valid, ppc_clear, ppc_sense, pp_poll, srq;
    logic [7:0] err_code, esr_events, dev_event, device_event_mask, sre_mask;
    logic [7:0] stb, dio_oe;
    logic [2:0] ppc_line;
    sru_req_t   req;
    sru_resp_t  resp;
    int         fails, checked, i;

    sru_top sru_top_i (.clk, .arst_n, .req_valid, .req, .req_ready, .resp_valid, .resp,
        .err_valid, .err_code, .err_serial, .echo_mode, .acq_single, .store_fixed, .ranging,
        .esr_events, .dev_event, .device_event_mask, .dev_event_clr(), .out_pending,
        .sre_mask, .spoll_ack, .stb, .srq, .ppc_valid, .ppc_clear, .ppc_sense,
        .ppc_line, .pp_poll, .dio_o(), .dio_oe);
    sru_host sru_host_i (.clk, .resp_valid, .resp, .req_valid, .req);

    // query with answer check, and command with no answer
    task automatic q(input sru_cmd_t c, input logic [7:0] a, input sru_rkind_t k,
                     input logic [7:0] e);
        logic v; sru_resp_t r;
        sru_host_i.ask(c, a, v, r);
        `CHK(v, 1'b1)
        `CHK(r.kind, k)
        `CHK(r.num, e)
    endtask
    task automatic w(input sru_cmd_t c, input logic [7:0] a);
        logic v; sru_resp_t r;
        sru_host_i.ask(c, a, v, r);
        `CHK(v, 1'b0)
    endtask
    // waiting complete query, then a cancelling command: no answer may follow
    task automatic drop(input sru_cmd_t c);
        ranging = 1'b1; w(CMD_OPC_RD, 8'h00); w(c, 8'h00); ranging = 1'b0;
        repeat (4) begin @(negedge clk); `CHK(resp_valid, 1'b0) end
    endtask
    // one-cycle error or event pulse
    task automatic err(input logic [7:0] c);
        @(negedge clk); err_valid = 1'b1; err_code = c;
        @(negedge clk); err_valid = 1'b0;
    endtask
    task automatic ev(input logic [7:0] e);
        @(negedge clk); esr_events = e;
        @(negedge clk); esr_events = '0;
    endtask
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // clock and watchdog
    initial begin clk = 1'b0; forever #25 clk = ~clk; end
    initial begin #2000000; fails++; end_of_test(); end

    // main sequence
    initial begin
        {arst_n, err_valid, err_serial, echo_mode, acq_single, store_fixed, ranging} = '0;
        {out_pending, spoll_ack, ppc_valid, ppc_clear, ppc_sense, pp_poll, ppc_line} = '0;
        {err_code, esr_events, dev_event, device_event_mask, sre_mask} = '0;
        fails = 0; checked = 0;
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        q(CMD_ESE_RD, 8'h00, RK_VALUE, 8'h00);
        q(CMD_PRE_RD, 8'h00, RK_VALUE, 8'h00);
        w(CMD_ESE_WR, 8'hFF);
        q(CMD_ESE_RD, 8'h00, RK_VALUE, 8'hFF);
        ev(8'h20); `CHK(stb[5], 1'b1)
        w(CMD_ESE_WR, 8'h10); `CHK(stb[5], 1'b0)
        q(CMD_ESR_RD, 8'h00, RK_VALUE, 8'h20);
        dev_event = 8'h81; device_event_mask = 8'h01;
        q(CMD_ESR_RD, 8'h00, RK_VALUE, 8'h08);
        q(CMD_ESR_RD, 8'h00, RK_VALUE, 8'h08);
        dev_event = '0;
        for (i = 0; i < 11; i++) err(8'hF0 - 8'(i));
        for (i = 0; i < 10; i++) q(CMD_ERR_RD, 8'h00, RK_ERROR, 8'hF0 - 8'(i));
        q(CMD_ERR_RD, 8'h00, RK_NOERR, NOERR);
        echo_mode = 1'b1; err_serial = 1'b1;
        err(8'hE0); `CHK(resp.num, 8'hE0)
        echo_mode = 1'b0; err_serial = 1'b0;
        q(CMD_ERR_RD, 8'h00, RK_NOERR, NOERR);
        ranging = 1'b1; w(CMD_OPC, 8'h00); repeat (5) @(negedge clk);
        q(CMD_ESR_RD, 8'h00, RK_VALUE, 8'h00);
        ranging = 1'b0; repeat (3) @(negedge clk);
        q(CMD_ESR_RD, 8'h00, RK_VALUE, 8'h01);
        ev(8'h01); err(8'hC0); out_pending = 1'b1; ranging = 1'b1;
        w(CMD_OPC, 8'h00); w(CMD_CLS, 8'h00); `CHK(stb, 8'h10)
        ranging = 1'b0; repeat (3) @(negedge clk);
        q(CMD_ESR_RD, 8'h00, RK_VALUE, 8'h00);
        q(CMD_ERR_RD, 8'h00, RK_NOERR, NOERR);
        drop(CMD_DCL);
        drop(CMD_RST);
        drop(CMD_CLS);
        w(CMD_OPC_RD, 8'h00); @(negedge clk);
        `CHK(resp_valid, 1'b1) `CHK(resp.num, OPC_ONE)
        q(CMD_IDN_RD, 8'h00, RK_IDN, IDN_SER);
        w(CMD_PRE_WR, 8'h10);
        q(CMD_PRE_RD, 8'h00, RK_VALUE, 8'h10);
        q(CMD_IST_RD, 8'h00, RK_VALUE, 8'h01);
        @(negedge clk); ppc_valid = 1'b1; ppc_sense = 1'b1; ppc_line = 3'd2;
        @(negedge clk); ppc_valid = 1'b0; pp_poll = 1'b1;
        repeat (4) @(negedge clk); `CHK(dio_oe, 8'h04)
        ppc_clear = 1'b1; @(negedge clk); ppc_clear = 1'b0;
        @(negedge clk); `CHK(dio_oe, 8'h00)
        sre_mask = 8'h10; @(negedge clk); `CHK(srq, 1'b1) `CHK(stb[6], 1'b1)
        spoll_ack = 1'b1; @(negedge clk); spoll_ack = 1'b0;
        repeat (2) @(negedge clk); `CHK(srq, 1'b0)
        pp_poll = 1'b0; out_pending = 1'b0;
        q(CMD_IST_RD, 8'h00, RK_VALUE, 8'h00);
        end_of_test();
    end
endmodule // sru_top_tb
`default_nettype wire
